// ---- rtl/kpd_pkg.sv ----
// constants and types shared by the keypad scan controller
package kpd_pkg;
    localparam logic [7:0] ADDR_DRIVE = 8'hD1;
    localparam logic [7:0] ADDR_SENSE = 8'hD2;
    localparam logic [7:0] ADDR_TIMING = 8'hD3;
    localparam logic [7:0] ADDR_CTRL = 8'hD4;
    localparam logic [7:0] ADDR_DIM = 8'hD5;

    localparam logic [4:0] RST_DRIVE = 5'h1F;
    localparam logic [5:0] RST_SENSE = 6'h3F;
    localparam logic [7:0] RST_TIMING = 8'h00;
    localparam logic [5:0] RST_DIM = 6'h00;

    // control/status bit positions
    localparam int CTRL_CLK_BIT = 3;
    localparam int CTRL_SCAN_BIT = 2;
    localparam int CTRL_FLAG_BIT = 1;
    localparam int CTRL_IEN_BIT = 0;
    // timing register fields
    localparam int DEB_LSB = 2;
    localparam int DEB_W = 6;
    localparam int STEP_LSB = 0;
    localparam int STEP_W = 2;
    // dimension register fields
    localparam int ROWS_LSB = 3;
    localparam int COLS_LSB = 0;
    localparam int DIM_W = 3;

    localparam int NUM_ROWS = 6;
    localparam int NUM_COLS = 5;
    localparam int ORDER_W = 15;

    // keypad clock period and per-unit counts
    localparam int KCLK_RATE_HZ = 1000;
    localparam int SYS_RATE_HZ = 100_000_000;
    localparam int KCLK_CYCLES = SYS_RATE_HZ / KCLK_RATE_HZ;
    localparam int DEB_UNIT_MS = 4;
    localparam logic [7:0] DEB_ZERO_UNITS = 8'h40;
    localparam logic [7:0] STEP_ZERO_MS = 8'h04;

    typedef enum logic [2:0] {
        KPD_IDLE,
        KPD_DEB_PRESS,
        KPD_SCAN,
        KPD_WAIT_REL,
        KPD_DEB_REL
    } kpd_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } kpd_bus_t;
endpackage

// ---- rtl/kpd_scan.sv ----
// keypad matrix scanner with register port, debounce and bypass mode
//
// Function
// (RULE1) sense register bits 5:0 mirror the six row inputs one to one
// (RULE2) in auto-scan the sense register holds the row pattern of the key
// (RULE3) in bypass software reads raw rows and decides on key presses
// (RULE4) debounce field bits 7:2 in 4 ms steps, zero means 256 ms
// (RULE5) same debounce interval confirms both press and release
// (RULE6) scan-step field bits 1:0 picks 1 to 4 ms per key
// (RULE7) scan step is the time spent on each key position
// (RULE8) status bit 3 reads the present keypad clock level
// (RULE9) bit 2 set enables hardware scan, clear means no hardware scan
// (RULE10) auto-scan sets key-detect flag and irq on a valid key
// (RULE11) bypass sets flag on a row falling edge after all rows high
// (RULE12) reading the status register clears the key-detect flag
// (RULE13) bypass row edge detection works with keypad clock stopped
// (RULE14) enable bit 0 gates only the interrupt, flag still sets
// (RULE15) row-count field bits 5:3 limits scanned rows, at most 6
// (RULE16) column-count field bits 2:0 limits scanned columns, at most 5
// (RULE17) size fields ignored in bypass, unused rows tied high outside
// (RULE18) in bypass the column outputs follow the drive-line register
// (RULE19) idle drives all columns low, debounces a row low, then scans
// (RULE20) several keys pressed reports none, then waits debounced release
// (RULE21) timing counts periods of a 1 kHz clock with its own enable
// (RULE22) debounce loads n periods of 4 ms, zero counts as 64
//
// The plain strobed port is this design's own decision.
module kpd_scan #(
    parameter int KCLK_DIV = kpd_pkg::KCLK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input kpd_pkg::kpd_bus_t bus,
    output logic [7:0] rd_data,
    input wire logic [5:0] row_in,
    output logic [4:0] col_drive,
    input wire logic kbd_clk_en,
    input wire logic [14:0] scan_order,
    output logic irq
);
    import kpd_pkg::*;

    localparam int DIV_W = 20;
    localparam int HALF_DIV = KCLK_DIV / 2;

    // an odd divider would truncate the half period and skew the 1 ms tick
    generate
        if (KCLK_DIV < 2 || KCLK_DIV >= (1 << DIV_W)
            || KCLK_DIV % 2 != 0) begin : g_div_check
            $error("kpd_scan: KCLK_DIV out of range or odd");
        end
    endgenerate

    typedef struct packed {
        logic [5:0] sync1;
        logic [5:0] sync2;
        logic [5:0] sync3;
        logic [5:0] rows;
        logic was_all_high;
        logic [DIV_W-1:0] div;
        logic kclk;
        // nine bits so the 256 ms debounce of a zero field fits
        logic [8:0] ms_cnt;
        kpd_state_t st;
        logic [2:0] col_idx;
        logic [2:0] row_idx;
        logic [1:0] hits;
        logic [2:0] hit_col;
        logic [2:0] hit_row;
        logic [4:0] drive_reg;
        logic [5:0] sense_hold;
        logic [7:0] timing;
        logic scan_en;
        logic flag;
        logic irq_en;
        logic [5:0] dim;
        logic [4:0] col_out;
        logic irq;
        logic [7:0] rdata;
    } kpd_regs_t;

    kpd_regs_t q;
    kpd_regs_t next_q;

    logic ms_tick;
    logic all_high;
    logic [2:0] n_rows;
    logic [2:0] n_cols;
    logic [2:0] cur_col;
    logic [8:0] deb_ms;
    logic [8:0] step_ms;
    logic [5:0] deb_units;
    logic [1:0] step_code;
    logic [5:0] sense_view;
    logic flag_set;
    logic flag_clr;
    logic [7:0] ctrl_view;

    assign rd_data = q.rdata;
    assign col_drive = q.col_out;
    assign irq = q.irq;

    always_comb begin
        deb_units = q.timing[DEB_LSB +: DEB_W];
        step_code = q.timing[STEP_LSB +: STEP_W];
        // n*4 ms, zero wraps to the longest interval
        if (deb_units == 6'h00) begin // RULE22
            deb_ms = 9'(DEB_ZERO_UNITS * DEB_UNIT_MS); // RULE4
        end else begin
            deb_ms = 9'(deb_units * DEB_UNIT_MS); // RULE4
        end
        // codes 1..3 give that many ms, code 0 gives 4 ms
        if (step_code == 2'h0) begin // RULE6
            step_ms = {1'b0, STEP_ZERO_MS};
        end else begin
            step_ms = {7'h00, step_code};
        end
        // out-of-range sizes fall back to the full matrix
        n_rows = q.dim[ROWS_LSB +: DIM_W]; // RULE15
        if (n_rows == 3'h0 || n_rows > 3'(NUM_ROWS)) begin
            n_rows = 3'(NUM_ROWS);
        end
        n_cols = q.dim[COLS_LSB +: DIM_W]; // RULE16
        if (n_cols == 3'h0 || n_cols > 3'(NUM_COLS)) begin
            n_cols = 3'(NUM_COLS);
        end
        cur_col = scan_order[q.col_idx * 3 +: 3];
        all_high = &q.rows;
        sense_view = q.scan_en ? q.sense_hold : q.rows; // RULE1 RULE2 RULE3
        ctrl_view = 8'h00;
        ctrl_view[CTRL_CLK_BIT] = q.kclk; // RULE8
        ctrl_view[CTRL_SCAN_BIT] = q.scan_en;
        ctrl_view[CTRL_FLAG_BIT] = q.flag;
        ctrl_view[CTRL_IEN_BIT] = q.irq_en;
        ms_tick = 1'b0;

        next_q = q;
        flag_set = 1'b0;
        flag_clr = bus.rd && bus.addr == ADDR_CTRL; // RULE12

        // rows pass three flops; a change counts once stages 2 and 3 agree
        next_q.sync1 = row_in;
        next_q.sync2 = q.sync1;
        next_q.sync3 = q.sync2;
        if (q.sync2 == q.sync3) begin
            next_q.rows = q.sync3;
        end

        // 1 kHz keypad clock; stops and holds its level when disabled
        if (kbd_clk_en) begin // RULE21
            if (q.div == DIV_W'(HALF_DIV - 1)) begin
                next_q.div = '0;
                next_q.kclk = ~q.kclk;
                ms_tick = q.kclk;
            end else begin
                next_q.div = q.div + 1'b1;
            end
        end

        // bypass edge detection runs on the system clock alone
        next_q.was_all_high = all_high;
        if (!q.scan_en && q.was_all_high && !all_high) begin // RULE11 RULE13
            flag_set = 1'b1;
        end

        if (ms_tick && q.ms_cnt != 9'h000) begin // RULE21
            next_q.ms_cnt = q.ms_cnt - 1'b1;
        end

        if (!q.scan_en) begin
            // size fields are left untouched in bypass; the scan state returns to KPD_IDLE
            next_q.st = KPD_IDLE; // RULE9 RULE17
            next_q.col_out = q.drive_reg; // RULE18
        end else begin
            case (q.st)
                KPD_IDLE: begin
                    next_q.col_out = 5'h00; // RULE19
                    if (!all_high) begin
                        next_q.st = KPD_DEB_PRESS;
                        next_q.ms_cnt = deb_ms; // RULE5
                    end
                end
                KPD_DEB_PRESS: begin
                    if (ms_tick && q.ms_cnt == 9'h001) begin
                        if (!all_high) begin // RULE19
                            next_q.st = KPD_SCAN;
                            next_q.col_idx = 3'h0;
                            next_q.row_idx = 3'h0;
                            next_q.hits = 2'h0;
                            next_q.ms_cnt = step_ms;
                        end else begin
                            next_q.st = KPD_IDLE;
                        end
                    end
                end
                KPD_SCAN: begin
                    // unused order codes drive no column low
                    next_q.col_out = 5'h1F;
                    if (cur_col < 3'(NUM_COLS)) begin
                        next_q.col_out[cur_col] = 1'b0;
                    end
                    if (ms_tick && q.ms_cnt == 9'h001) begin // RULE7
                        next_q.ms_cnt = step_ms;
                        if (!q.rows[q.row_idx]) begin
                            next_q.hits = (q.hits == 2'h2) ? 2'h2
                                : q.hits + 1'b1;
                            next_q.hit_col = cur_col;
                            next_q.hit_row = q.row_idx;
                        end
                        if (q.row_idx == n_rows - 1'b1) begin // RULE15
                            next_q.row_idx = 3'h0;
                            if (q.col_idx == n_cols - 1'b1) begin // RULE16
                                next_q.st = KPD_WAIT_REL;
                            end else begin
                                next_q.col_idx = q.col_idx + 1'b1;
                            end
                        end else begin
                            next_q.row_idx = q.row_idx + 1'b1;
                        end
                    end
                end
                KPD_WAIT_REL: begin
                    // only a single hit counts as a valid key
                    if (q.hits == 2'h1) begin // RULE20
                        next_q.hits = 2'h0;
                        next_q.drive_reg = 5'h1F;
                        next_q.drive_reg[q.hit_col] = 1'b0;
                        next_q.sense_hold = 6'h3F; // RULE2
                        next_q.sense_hold[q.hit_row] = 1'b0;
                        flag_set = 1'b1; // RULE10
                    end
                    next_q.col_out = 5'h00;
                    if (all_high) begin
                        next_q.st = KPD_DEB_REL;
                        next_q.ms_cnt = deb_ms; // RULE5
                    end
                end
                KPD_DEB_REL: begin
                    next_q.col_out = 5'h00;
                    if (!all_high) begin // RULE20
                        next_q.ms_cnt = deb_ms;
                    end else if (ms_tick && q.ms_cnt == 9'h001) begin
                        next_q.st = KPD_IDLE;
                    end
                end
                default: begin
                    next_q.st = KPD_IDLE;
                end
            endcase
        end

        // register writes; a hardware key capture in the same cycle wins
        if (bus.wr) begin
            case (bus.addr)
                ADDR_DRIVE: begin
                    if (!(q.scan_en && q.st == KPD_WAIT_REL
                          && q.hits == 2'h1)) begin
                        next_q.drive_reg = bus.wdata[4:0];
                    end
                end
                ADDR_TIMING: next_q.timing = bus.wdata;
                ADDR_CTRL: begin
                    next_q.scan_en = bus.wdata[CTRL_SCAN_BIT]; // RULE9
                    next_q.irq_en = bus.wdata[CTRL_IEN_BIT];
                end
                ADDR_DIM: next_q.dim = bus.wdata[5:0];
                default: begin
                end
            endcase
        end

        // set wins over the clear-on-read
        if (flag_set) begin
            next_q.flag = 1'b1;
        end else if (flag_clr) begin
            next_q.flag = 1'b0;
        end
        next_q.irq = next_q.flag && next_q.irq_en; // RULE14

        if (bus.rd) begin
            case (bus.addr)
                ADDR_DRIVE: next_q.rdata = {3'h0, q.drive_reg};
                ADDR_SENSE: next_q.rdata = {2'h0, sense_view}; // RULE1
                ADDR_TIMING: next_q.rdata = q.timing;
                ADDR_CTRL: next_q.rdata = ctrl_view;
                ADDR_DIM: next_q.rdata = {2'h0, q.dim};
                default: next_q.rdata = 8'h00;
            endcase
        end else begin
            next_q.rdata = 8'h00;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.sync1 <= RST_SENSE;
            q.sync2 <= RST_SENSE;
            q.sync3 <= RST_SENSE;
            q.rows <= RST_SENSE;
            q.was_all_high <= 1'b1;
            q.st <= KPD_IDLE;
            q.drive_reg <= RST_DRIVE;
            q.sense_hold <= RST_SENSE;
            q.timing <= RST_TIMING;
            q.dim <= RST_DIM;
            q.col_out <= RST_DRIVE;
        end else begin
            q <= next_q;
        end
    end
endmodule

// ---- bench/kpd_scan_chk.sv ----
// bound checker for the keypad scan controller ports
module kpd_scan_chk #(
    parameter int KCLK_DIV = 20
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input kpd_pkg::kpd_bus_t bus,
    input wire logic [7:0] rd_data,
    input wire logic [5:0] row_in,
    input wire logic [4:0] col_drive,
    input wire logic kbd_clk_en,
    input wire logic [14:0] scan_order,
    input wire logic irq
);
    import kpd_pkg::*;
    logic scan_en;
    logic ien;
    // shadow of the control bits, rebuilt from bus writes alone
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            scan_en <= 1'b0;
            ien <= 1'b0;
        end else if (bus.wr && bus.addr == ADDR_CTRL) begin
            scan_en <= bus.wdata[CTRL_SCAN_BIT];
            ien <= bus.wdata[CTRL_IEN_BIT];
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence s_rows_high;
        (!scan_en && ien && row_in == 6'h3F)[*8];
    endsequence
    sequence s_quiet_low;
        (!bus.rd && !bus.wr && row_in != 6'h3F)[*8];
    endsequence
    a_rd_idle_zero: assert property (!bus.rd |=> rd_data == 8'h00)
        else $error("read data outside read slot");
    a_irq_gated: assert property (!ien |-> !irq)
        else $error("interrupt while disabled");
    a_irq_rd_en: assert property (bus.rd && bus.addr == ADDR_CTRL
        |=> !irq || rd_data[CTRL_IEN_BIT]) else $error("irq vs enable");
    a_sense_mirror: assert property (
        (!scan_en && $stable(row_in))[*8] ##0
        (bus.rd && bus.addr == ADDR_SENSE)
        |=> rd_data == {2'b00, $past(row_in)}) else $error("sense wrong");
    a_drive_follow: assert property (
        !scan_en && bus.wr && bus.addr == ADDR_DRIVE ##1 !bus.wr
        |=> col_drive == $past(bus.wdata[4:0], 2)) else $error("drive wrong");
    a_idle_low: assert property (
        !scan_en && bus.wr && bus.addr == ADDR_CTRL
        && bus.wdata[CTRL_SCAN_BIT] && row_in == 6'h3F
        |-> ##[1:3] col_drive == 5'h00) else $error("idle columns not low");
    a_scan_cols: assert property (scan_en && $past(scan_en, 2)
        |-> col_drive == 5'h00 || $onehot0(~col_drive))
        else $error("several columns driven");
    a_bypass_irq: assert property (s_rows_high ##1 s_quiet_low |-> irq)
        else $error("no interrupt on row edge");
endmodule

bind kpd_scan kpd_scan_chk #(.KCLK_DIV(KCLK_DIV)) i_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
    .row_in(row_in), .col_drive(col_drive), .kbd_clk_en(kbd_clk_en),
    .scan_order(scan_order), .irq(irq));

// ---- bench/kpd_keypad.sv ----
// switch-matrix keypad: a closed key pulls its row to a driven column
module kpd_keypad (
    input wire logic [4:0] col_drive,
    input wire logic [29:0] keys,
    output logic [5:0] row_in
);
    // rows have pull-ups, so open and unused rows read high
    always_comb begin
        row_in = 6'h3F;
        for (int c = 0; c < 5; c++) begin
            for (int r = 0; r < 6; r++) begin
                if (keys[c * 6 + r] && !col_drive[c]) begin
                    row_in[r] = 1'b0;
                end
            end
        end
    end
endmodule

// ---- bench/tb_kpd_scan.sv ----
// self-checking bench for the keypad scan controller
module tb_kpd_scan;
    timeunit 1ns;
    timeprecision 1ps;
    import kpd_pkg::*;
    localparam int DIV = 20;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    kpd_bus_t bus = '0;
    logic [7:0] rd_data;
    logic [5:0] row_in;
    logic [4:0] col_drive;
    logic kbd_clk_en = 1'b0;
    logic [14:0] scan_order = 15'h4688; // columns 0..4 in order
    logic irq;
    logic [29:0] keys = '0;
    logic [31:0] seed = 32'd29206;
    int errors = 0;
    int cmp_count = 0;
    always #5 clk_sys = ~clk_sys;
    kpd_scan #(.KCLK_DIV(DIV)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .bus(bus), .rd_data(rd_data), .row_in(row_in),
        .col_drive(col_drive), .kbd_clk_en(kbd_clk_en),
        .scan_order(scan_order), .irq(irq));
    kpd_keypad i_pad (.col_drive(col_drive), .keys(keys), .row_in(row_in));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] one_low(input int n, input logic [7:0] m);
        return m & ~(8'h01 << n);
    endfunction
    // press to report: debounce, then every position at the step time
    function automatic int span(input int deb, input int st, input int pos);
        return (DEB_UNIT_MS * deb + pos * (st == 0 ? 4 : st)) * DIV;
    endfunction
    task automatic stop_test();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_span(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            errors++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus <= '0;
        @(negedge clk_sys);
        d = rd_data;
    endtask
    task automatic rd_chk(input logic [7:0] a, m, e);
        logic [7:0] d;
        rd(a, d);
        chk_reg(d & m, e);
    endtask
    initial begin
        repeat (60000) @(posedge clk_sys);
        errors++;
        stop_test();
    end
    initial begin
        logic [7:0] d;
        logic [7:0] d2;
        int c, r, n, deb, rows, cols, lo;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_chk(ADDR_DRIVE, 8'hFF, 8'h1F);
        rd_chk(ADDR_SENSE, 8'hFF, 8'h3F);
        rd_chk(ADDR_TIMING, 8'hFF, 8'h00);
        rd_chk(ADDR_CTRL, 8'hF7, 8'h00);
        rd_chk(ADDR_DIM, 8'hFF, 8'h00);
        rd_chk(8'hD6, 8'hFF, 8'h00);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wr(ADDR_TIMING, seed[7:0]);
            wr(ADDR_DIM, seed[15:8]);
            wr(ADDR_SENSE, seed[23:16]);
            rd_chk(ADDR_TIMING, 8'hFF, seed[7:0]);
            rd_chk(ADDR_DIM, 8'hFF, {2'b00, seed[13:8]});
            rd_chk(ADDR_SENSE, 8'hFF, 8'h3F);
        end
        // bypass with the keypad clock stopped, interrupt enable toggling
        for (r = 0; r < 6; r++) begin
            seed = xs(seed);
            c = seed[7:0] % 5;
            wr(ADDR_CTRL, {7'h00, r[0]});
            wr(ADDR_DRIVE, one_low(c, 8'h1F));
            repeat (10) @(negedge clk_sys);
            chk_reg({3'b000, col_drive}, one_low(c, 8'h1F));
            @(posedge clk_sys);
            keys <= 30'h1 << (c * 6 + r);
            repeat (10) @(negedge clk_sys);
            chk_reg({7'h00, irq}, {7'h00, r[0]});
            rd_chk(ADDR_SENSE, 8'hFF, one_low(r, 8'h3F));
            rd_chk(ADDR_CTRL, 8'hF7, {6'h00, 1'b1, r[0]});
            rd_chk(ADDR_CTRL, 8'hF7, {7'h00, r[0]});
            chk_reg({7'h00, irq}, 8'h00);
            @(posedge clk_sys);
            keys <= '0;
            repeat (10) @(posedge clk_sys);
        end
        kbd_clk_en <= 1'b1;
        rd(ADDR_CTRL, d);
        repeat (8) @(posedge clk_sys);
        rd(ADDR_CTRL, d2);
        chk_reg({7'h00, d2[CTRL_CLK_BIT]}, {7'h00, ~d[CTRL_CLK_BIT]});
        wr(ADDR_CTRL, 8'h05);
        // hardware scan: every step code, random size and key inside it
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            deb = 1 + seed[7:0] % 3;
            rows = 1 + seed[15:8] % 6;
            cols = 1 + seed[23:16] % 5;
            c = seed[27:24] % cols;
            r = seed[31:28] % rows;
            wr(ADDR_TIMING, {deb[5:0], i[1:0]});
            wr(ADDR_DIM, {2'b00, rows[2:0], cols[2:0]});
            @(posedge clk_sys);
            keys <= 30'h1 << (c * 6 + r);
            for (n = 0; n < 4000 && irq !== 1'b1; n++) @(negedge clk_sys);
            // first debounce tick may come up to one ms early
            lo = span(deb, i, rows * cols) - DIV;
            chk_span(n, lo, lo + 2 * DIV + 2 * rows * cols + 20);
            rd_chk(ADDR_DRIVE, 8'hFF, one_low(c, 8'h1F));
            rd_chk(ADDR_SENSE, 8'hFF, one_low(r, 8'h3F));
            rd_chk(ADDR_CTRL, 8'hF7, 8'h07);
            rd_chk(ADDR_CTRL, 8'hF7, 8'h05);
            @(posedge clk_sys);
            keys <= '0;
            repeat (span(deb + 2, 0, 0)) @(posedge clk_sys);
        end
        // two keys at once are never reported
        wr(ADDR_DIM, 8'h35);
        @(posedge clk_sys);
        keys <= 30'h3;
        for (n = 0; n < 3000 && irq !== 1'b1; n++) @(negedge clk_sys);
        chk_reg({7'h00, irq}, 8'h00);
        rd_chk(ADDR_CTRL, 8'hF7, 8'h05);
        stop_test();
    end
endmodule
